/* File: hdl/ascp_serial_port.sv */
`timescale 1ns/100ps
module ascp_serial_port
  import ascp_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             cs_n,
  input  wire logic             sclk,
  input  wire logic             data_in,
  output logic                  data_out,
  output logic                  data_oe,
  input  wire logic             fixed_variant,
  input  wire logic             wide_config,
  output logic                  conv_start,
  output logic                  input_mode_bit,
  output logic                  conv_odd_sign,
  output logic [1:0]            conv_channel_sel,
  output logic                  unipolar_select,
  output logic                  bit_order_select,
  input  wire logic [RES_W-1:0] result_data,
  input  wire logic             result_valid,
  output logic                  result_ready,
  output logic                  busy,
  output logic                  underrun
);

  // configuration word length for the variant in use
  function automatic logic [2:0] cfg_len(input logic wide);
    cfg_len = wide ? CFG_LEN_LONG : CFG_LEN_SHORT;
  endfunction

  // bit sent at a given position of the MSB-first run
  function automatic logic msb_bit(input logic [RES_W-1:0] res,
                                   input logic [3:0] pos);
    msb_bit = res[RES_TOP - pos];
  endfunction

  ascp_state_t      state_reg;     // sequencer state
  logic             sclk_prev_reg; // last sampled shift clock level
  logic             sclk_rise;     // shift clock went high this cycle
  logic             sclk_fall;     // shift clock went low this cycle
  logic [CFG_W-1:0] cfg_shift_reg; // configuration bits received so far
  logic [CFG_W-1:0] cfg_word;      // word including the bit now sampled
  logic [2:0]       cfg_cnt_reg;   // configuration bits received
  logic [3:0]       bit_cnt_reg;   // position inside the result runs
  logic [RES_W-1:0] res_reg;       // result being shifted out
  logic             out_reg;       // level launched on the data pin
  logic             oe_reg;        // data pin driven
  logic             start_reg;     // one-cycle conversion request
  logic             underrun_reg;  // result missing at the null bit
  logic             last_cfg;      // final configuration bit arrives now
  logic [RES_W-1:0] fifo_data;     // head of the result buffer
  logic             fifo_valid;    // buffer holds a result
  logic             fifo_pop;      // take the head now

  // shift clock is a synchronous input; edges found against its last level
  assign sclk_rise = sclk && !sclk_prev_reg;
  assign sclk_fall = !sclk && sclk_prev_reg;

  // the bit being sampled is appended combinationally, so the completing bit is decoded in its own cycle
  assign cfg_word = {cfg_shift_reg[CFG_W-2:0], data_in};
  assign last_cfg = (state_reg == ASCP_CONFIG) && sclk_rise && !cs_n
                    && (cfg_cnt_reg == cfg_len(wide_config) - 3'h1);

  // the head is taken at the falling edge that ends the null bit
  assign fifo_pop = (state_reg == ASCP_NULL) && sclk_fall && !cs_n;

  // results queue here so a slow host stalls the converter core only when
  // the buffer is full or select is high, both pushing back through result_ready
  ascp_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_result_fifo (
    .clk      (clk),
    .arst_n   (arst_n),
    .flush    (cs_n),
    .wr_data  (result_data),
    .wr_valid (result_valid),
    .wr_ready (result_ready),
    .rd_data  (fifo_data),
    .rd_ready (fifo_pop),
    .rd_valid (fifo_valid)
  );

  // remember the previous shift clock level for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_reg <= 1'h0;
    end else begin
      sclk_prev_reg <= sclk;
    end
  end

  // sequencer; a high select overrides everything and parks the port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ASCP_IDLE;
    end else if (cs_n) begin
      state_reg <= ASCP_IDLE;
    end else begin
      case (state_reg)
        ASCP_IDLE: begin
          // select has just fallen: a new exchange opens
          if (fixed_variant) begin
            state_reg <= ASCP_ARM;
          end else begin
            state_reg <= ASCP_HUNT;
          end
        end
        ASCP_HUNT: begin
          // leading zeros are passed over
          if (sclk_rise && data_in) begin
            state_reg <= ASCP_CONFIG;
          end
        end
        ASCP_CONFIG: begin
          if (last_cfg) begin
            state_reg <= ASCP_ARM;
          end
        end
        ASCP_ARM: begin
          // next falling edge launches the null bit
          if (sclk_fall) begin
            state_reg <= ASCP_NULL;
          end
        end
        ASCP_NULL: begin
          if (sclk_fall) begin
            state_reg <= ASCP_MSB;
          end
        end
        ASCP_MSB: begin
          if (sclk_fall && (bit_cnt_reg == RES_TOP)) begin
            // order one ends in zeros, otherwise the run is repeated reversed
            if (bit_order_select) begin
              state_reg <= ASCP_FILL;
            end else begin
              state_reg <= ASCP_LSB;
            end
          end
        end
        ASCP_LSB: begin
          if (sclk_fall && (bit_cnt_reg == RES_TOP)) begin
            state_reg <= ASCP_FILL;
          end
        end
        ASCP_FILL: begin
          // zeros for as long as the host keeps clocking
          state_reg <= ASCP_FILL;
        end
        default: begin
          state_reg <= ASCP_IDLE;
        end
      endcase
    end
  end

  // configuration shift register and its bit count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_shift_reg <= '0;
      cfg_cnt_reg   <= 3'h0;
    end else if (cs_n) begin
      cfg_shift_reg <= '0;
      cfg_cnt_reg   <= 3'h0;
    end else if ((state_reg == ASCP_CONFIG) && sclk_rise) begin
      // sampled on the rising edge; nothing is taken once the word is whole
      cfg_shift_reg <= cfg_word;
      cfg_cnt_reg   <= cfg_cnt_reg + 3'h1;
    end
  end

  // applied configuration, held until the next word completes or a fixed-variant exchange opens
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      input_mode_bit   <= RST_MODE;
      conv_odd_sign    <= RST_ODD;
      conv_channel_sel <= RST_SEL;
      unipolar_select  <= RST_UNI;
      bit_order_select <= RST_ORDER;
    end else if ((state_reg == ASCP_IDLE) && !cs_n && fixed_variant) begin
      // fixed variant: one differential pair, unipolar, reversed repeat
      input_mode_bit   <= FIXED_MODE;
      conv_odd_sign    <= FIXED_ODD;
      conv_channel_sel <= FIXED_SEL;
      unipolar_select  <= FIXED_UNI;
      bit_order_select <= 1'h0;
    end else if (last_cfg) begin
      if (wide_config) begin
        // host order: mode, odd/sign, select high, select low, uni, order
        input_mode_bit   <= cfg_word[LONG_MODE_POS];
        conv_odd_sign    <= cfg_word[LONG_ODD_POS];
        conv_channel_sel <= {cfg_word[LONG_SEL1_POS], cfg_word[LONG_SEL0_POS]};
        unipolar_select  <= cfg_word[LONG_UNI_POS];
        bit_order_select <= cfg_word[LONG_ORDER_POS];
      end else begin
        // short word has no select and no polarity field
        input_mode_bit   <= cfg_word[SHORT_MODE_POS];
        conv_odd_sign    <= cfg_word[SHORT_ODD_POS];
        conv_channel_sel <= RST_SEL;
        unipolar_select  <= RST_UNI;
        bit_order_select <= cfg_word[SHORT_ORDER_POS];
      end
    end
  end

  // conversion request pulse, one per exchange, with the fields above
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_reg <= 1'h0;
    end else begin
      start_reg <= last_cfg
                   || ((state_reg == ASCP_IDLE) && !cs_n && fixed_variant);
    end
  end

  // result capture and position within the output runs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      res_reg     <= '0;
      bit_cnt_reg <= 4'h0;
    end else if (cs_n) begin
      bit_cnt_reg <= 4'h0;
    end else if (fifo_pop) begin
      // a missing result is sent as zeros rather than stalling the host
      res_reg     <= fifo_valid ? fifo_data : '0;
      bit_cnt_reg <= 4'h0;
    end else if (sclk_fall && (state_reg == ASCP_MSB)) begin
      // the reversed run shares the last bit, so it starts at position one
      bit_cnt_reg <= (bit_cnt_reg == RES_TOP) ? 4'h1 : bit_cnt_reg + 4'h1;
    end else if (sclk_fall && (state_reg == ASCP_LSB)) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // output level, launched on falling edges only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_reg <= 1'h0;
    end else if (cs_n) begin
      out_reg <= 1'h0;
    end else if (sclk_fall) begin
      case (state_reg)
        ASCP_ARM: begin
          out_reg <= 1'h0;
        end
        ASCP_NULL: begin
          // first result bit, straight from the buffer head
          out_reg <= fifo_valid ? fifo_data[RES_TOP] : 1'h0;
        end
        ASCP_MSB: begin
          if (bit_cnt_reg == RES_TOP) begin
            out_reg <= bit_order_select ? 1'h0 : res_reg[1];
          end else begin
            out_reg <= msb_bit(res_reg, bit_cnt_reg + 4'h1);
          end
        end
        ASCP_LSB: begin
          if (bit_cnt_reg == RES_TOP) begin
            out_reg <= 1'h0;
          end else begin
            out_reg <= res_reg[bit_cnt_reg + 4'h1];
          end
        end
        default: begin
          out_reg <= 1'h0;
        end
      endcase
    end
  end

  // output enable: off while receiving so a shared wire stays free
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_reg <= 1'h0;
    end else if (cs_n) begin
      oe_reg <= 1'h0;
    end else if ((state_reg == ASCP_ARM) && sclk_fall) begin
      oe_reg <= 1'h1;
    end
  end

  // flags a null bit that ended with no result in the buffer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      underrun_reg <= 1'h0;
    end else begin
      underrun_reg <= fifo_pop && !fifo_valid;
    end
  end

  // select gates the enable directly so release costs no extra cycle
  assign data_oe    = oe_reg && !cs_n;
  assign data_out   = out_reg;
  assign conv_start = start_reg;
  assign busy       = (state_reg != ASCP_IDLE);
  assign underrun   = underrun_reg;

endmodule

/* File: pkg/ascp_pkg.sv */
// shared constants and types of the converter serial control port
package ascp_pkg;

  // width of one conversion code
  localparam int unsigned RES_W = 10;
  // index of the most significant result bit
  localparam logic [3:0] RES_TOP = 4'h9;
  // configuration word length, three-field and six-field variants
  localparam logic [2:0] CFG_LEN_SHORT = 3'h3;
  localparam logic [2:0] CFG_LEN_LONG  = 3'h6;
  // width of the configuration shift register
  localparam int unsigned CFG_W = 6;
  // result fifo shape
  localparam int unsigned FIFO_W = 10;
  localparam int unsigned FIFO_D = 8;
  // field positions inside a completed six-bit word, first bit received on top
  localparam int unsigned LONG_MODE_POS  = 5;
  localparam int unsigned LONG_ODD_POS   = 4;
  localparam int unsigned LONG_SEL1_POS  = 3;
  localparam int unsigned LONG_SEL0_POS  = 2;
  localparam int unsigned LONG_UNI_POS   = 1;
  localparam int unsigned LONG_ORDER_POS = 0;
  // field positions inside a completed three-bit word
  localparam int unsigned SHORT_MODE_POS  = 2;
  localparam int unsigned SHORT_ODD_POS   = 1;
  localparam int unsigned SHORT_ORDER_POS = 0;
  // configuration applied by the fixed variant: differential, unipolar
  localparam logic       FIXED_MODE = 1'h0;
  localparam logic       FIXED_ODD  = 1'h0;
  localparam logic [1:0] FIXED_SEL  = 2'h0;
  localparam logic       FIXED_UNI  = 1'h1;
  // reset values of the applied configuration
  localparam logic       RST_MODE  = 1'h0;
  localparam logic       RST_ODD   = 1'h0;
  localparam logic [1:0] RST_SEL   = 2'h0;
  localparam logic       RST_UNI   = 1'h1;
  localparam logic       RST_ORDER = 1'h1;

  // port sequencer states
  typedef enum logic [2:0] {
    ASCP_IDLE,
    ASCP_HUNT,
    ASCP_CONFIG,
    ASCP_ARM,
    ASCP_NULL,
    ASCP_MSB,
    ASCP_LSB,
    ASCP_FILL
  } ascp_state_t;

endpackage

/* File: hdl/ascp_fifo.sv */
`timescale 1ns/100ps
// result buffer between the converter core and the serial shifter
module ascp_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  output logic      [WIDTH-1:0] rd_data,
  input  wire logic             rd_ready,
  output logic                  rd_valid
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // storage words
  logic [AW-1:0]    wr_ptr_reg;    // next slot to write
  logic [AW-1:0]    rd_ptr_reg;    // oldest slot
  logic [AW:0]      count_reg;     // words held
  logic             push;          // accepted write
  logic             pop;           // accepted read

  // honest flags from the occupancy count, both forced low during flush
  assign wr_ready = (count_reg != (AW+1)'(DEPTH)) && !flush;
  assign rd_valid = (count_reg != '0) && !flush;
  assign rd_data  = mem[rd_ptr_reg];
  assign push     = wr_valid && wr_ready;
  assign pop      = rd_ready && rd_valid;

  // storage array, written only on an accepted push
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= wr_data;
    end
  end

  // pointers and count; flush empties the buffer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end

endmodule

/* File: tb/ascp_serial_port_asserts.sv */
`timescale 1ns/100ps
// port-level checker of the serial control port
module ascp_serial_port_asserts
  import ascp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic data_out,
  input wire logic data_oe,
  input wire logic fixed_variant,
  input wire logic conv_start,
  input wire logic input_mode_bit,
  input wire logic unipolar_select,
  input wire logic result_ready,
  input wire logic busy,
  input wire logic underrun
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic [1:0] start_cnt_reg; // conversion requests in this exchange

  // count requests per exchange; saturates so a runaway is still seen
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_cnt_reg <= 2'h0;
    end else if (cs_n) begin
      start_cnt_reg <= 2'h0;
    end else if (conv_start && start_cnt_reg != 2'h3) begin
      start_cnt_reg <= start_cnt_reg + 2'h1;
    end
  end

  // a launch is allowed one or two cycles after the fall is seen
  sequence s_fall_seen;
    (!$past(sclk) && $past(sclk, 2)) || (!$past(sclk, 2) && $past(sclk, 3));
  endsequence

  a_oe_off_deselect: assert property (cs_n |-> !data_oe)
    else $error("output enabled while deselected");
  a_oe_fresh_select: assert property ($fell(cs_n) |-> !data_oe ##1 !data_oe)
    else $error("output enabled as select fell");
  a_ready_deselect: assert property (cs_n |-> !result_ready)
    else $error("result accepted while deselected");
  a_idle_deselect: assert property (cs_n [*2] |-> !busy)
    else $error("port busy after deselect");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion request longer than one cycle");
  a_one_start: assert property (conv_start |-> start_cnt_reg == 2'h0)
    else $error("second conversion request in one exchange");
  a_oe_after_cfg: assert property (data_oe |-> start_cnt_reg != 2'h0)
    else $error("output driven before configuration done");
  a_null_on_fall: assert property (
    !$past(cs_n) && $rose(data_oe) |-> !data_out and s_fall_seen)
    else $error("output not enabled with a null bit on a fall");
  a_out_on_fall: assert property (
    !cs_n && !$past(cs_n) && $changed(data_out) |-> s_fall_seen)
    else $error("output bit changed off a falling shift edge");
  a_fixed_cfg: assert property (
    fixed_variant && conv_start |-> !input_mode_bit && unipolar_select)
    else $error("fixed variant not differential unipolar");

  c_fixed: cover property (fixed_variant && conv_start);
  c_underrun: cover property (underrun);
  c_enable: cover property ($rose(data_oe));
  c_full: cover property (!cs_n && !result_ready);
endmodule

bind ascp_serial_port ascp_serial_port_asserts u_ascp_serial_port_asserts (
  .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk), .data_out(data_out),
  .data_oe(data_oe), .fixed_variant(fixed_variant), .conv_start(conv_start),
  .input_mode_bit(input_mode_bit), .unipolar_select(unipolar_select),
  .result_ready(result_ready), .busy(busy), .underrun(underrun));

/* File: tb/ascp_host_model.sv */
`timescale 1ns/100ps
// host serial port: select, shift clock and one shared data wire
module ascp_host_model (
  input  wire logic clk,
  input  wire logic data_out,
  input  wire logic data_oe,
  output logic      cs_n,
  output logic      sclk,
  output logic      data_in
);
  logic drv_reg; // host level on the shared wire

  // device wins while enabled; a released host wire toggles, never a stale level
  assign data_in = data_oe ? data_out : drv_reg;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    drv_reg = 1'b0;
  end

  // select edge; shift clock parked low so no stray edge starts a frame
  task automatic sel(input logic lvl);
    @(posedge clk);
    cs_n <= lvl;
    sclk <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // one period: launch on the fall, sample the device just before the rise
  task automatic shift(input logic din, input logic rel, output logic dout);
    @(posedge clk);
    sclk <= 1'b0;
    drv_reg <= rel ? ~drv_reg : din;
    repeat (4) @(posedge clk);
    dout = data_out;
    sclk <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* File: tb/ascp_serial_port_tb.sv */
`timescale 1ns/100ps
module ascp_serial_port_tb;
  import ascp_pkg::*;
  logic             clk, arst_n, cs_n, sclk, data_in, data_out, data_oe;
  logic             fixed_variant, wide_config, conv_start, input_mode_bit;
  logic             conv_odd_sign, unipolar_select, bit_order_select;
  logic [1:0]       conv_channel_sel;
  logic             result_valid, result_ready, busy, underrun;
  logic [RES_W-1:0] result_data;
  logic             und_seen, start_seen; // pulses caught between checks
  int               n_fail, n_tests, cyc;

  ascp_serial_port u_ascp_serial_port (.clk(clk), .arst_n(arst_n), .cs_n(cs_n),
    .sclk(sclk), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .fixed_variant(fixed_variant), .wide_config(wide_config), .conv_start(conv_start),
    .input_mode_bit(input_mode_bit), .conv_odd_sign(conv_odd_sign),
    .conv_channel_sel(conv_channel_sel), .unipolar_select(unipolar_select),
    .bit_order_select(bit_order_select), .result_data(result_data),
    .result_valid(result_valid), .result_ready(result_ready), .busy(busy),
    .underrun(underrun));

  ascp_host_model u_ascp_host_model (.clk(clk), .data_out(data_out),
    .data_oe(data_oe), .cs_n(cs_n), .sclk(sclk), .data_in(data_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // pulse catcher and hang guard; ceiling is about fifteen times the expected run of some 1300 cycles
  always @(posedge clk) begin
    if (underrun) und_seen <= 1'b1;
    if (conv_start) start_seen <= 1'b1;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // core side: n back-to-back results, one per edge
  task automatic push(input int n, input logic [RES_W-1:0] code);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      result_data <= code + RES_W'(i);
      result_valid <= 1'b1;
    end
    @(posedge clk);
    result_valid <= 1'b0;
  endtask

  // expected line bit i after the word: null, msb-first, then lsb-first or zeros
  function automatic logic exp_bit(input logic [RES_W-1:0] c, input logic o0, input int i);
    if (i == 0 || i > 19 || (i > 10 && !o0)) return 1'b0;
    return (i <= 10) ? c[10-i] : c[i-10];
  endfunction

  // one exchange; und leaves the fifo empty so zeros must come out
  task automatic frame(input logic fix, input logic wide, input logic [5:0] cfg,
                       input logic [RES_W-1:0] code, input logic und);
    logic             b;
    logic [RES_W-1:0] ec;
    ec = und ? '0 : code;
    fixed_variant <= fix;
    wide_config <= wide;
    start_seen = 1'b0;
    und_seen = 1'b0;
    u_ascp_host_model.sel(1'b0);
    if (!und) push(1, code);
    if (!fix) begin
      // leading zeros are not a start bit
      for (int i = 0; i < 2; i++) u_ascp_host_model.shift(1'b0, 1'b0, b);
      u_ascp_host_model.shift(1'b1, 1'b0, b);
      for (int i = (wide ? 5 : 2); i >= 0; i--) u_ascp_host_model.shift(cfg[i], 1'b0, b);
      check(data_oe, 1'b0);
      if (wide)
        check({input_mode_bit, conv_odd_sign, conv_channel_sel, unipolar_select,
               bit_order_select}, cfg);
      else
        check({input_mode_bit, conv_odd_sign, conv_channel_sel, unipolar_select,
               bit_order_select}, {cfg[2:1], 2'h0, 1'b1, cfg[0]});
    end else begin
      check({input_mode_bit, conv_odd_sign, conv_channel_sel, unipolar_select},
            {FIXED_MODE, FIXED_ODD, FIXED_SEL, FIXED_UNI});
      // first pulse: no fall since the clock is parked low, its rise leaves the pin off; the next fall launches the null bit
      u_ascp_host_model.shift(1'b0, 1'b1, b);
      check(data_oe, 1'b0);
    end
    // host lets the wire go; toggling input must not disturb the result
    for (int i = 0; i < 24; i++) begin
      u_ascp_host_model.shift(1'b0, 1'b1, b);
      check(b, exp_bit(ec, fix | ~cfg[0], i));
    end
    check({start_seen, und_seen}, {1'b1, und});
    u_ascp_host_model.sel(1'b1);
    check({busy, data_oe, result_ready}, 3'h0);
  endtask

  initial begin
    logic b;
    arst_n = 1'b0;
    fixed_variant = 1'b0;
    wide_config = 1'b0;
    result_valid = 1'b0;
    result_data = '0;
    und_seen = 1'b0;
    start_seen = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check({input_mode_bit, conv_odd_sign, conv_channel_sel, unipolar_select,
           bit_order_select, busy, data_oe},
          {RST_MODE, RST_ODD, RST_SEL, RST_UNI, RST_ORDER, 2'h0});
    frame(1'b0, 1'b1, 6'h29, 10'h2b5, 1'b0);
    frame(1'b0, 1'b0, 6'h06, 10'h1c3, 1'b0);
    frame(1'b1, 1'b0, 6'h00, 10'h3a6, 1'b0);
    frame(1'b0, 1'b1, 6'h1c, 10'h3ff, 1'b0);
    // fill the buffer until it refuses, then abort in mid word
    u_ascp_host_model.sel(1'b0);
    push(8, 10'h100);
    @(negedge clk);
    check(result_ready, 1'b0);
    u_ascp_host_model.shift(1'b1, 1'b0, b);
    u_ascp_host_model.shift(1'b1, 1'b0, b);
    u_ascp_host_model.sel(1'b1);
    check({busy, result_ready}, 2'h0);
    // flushed buffer: the next exchange finds no result
    frame(1'b0, 1'b1, 6'h03, 10'h155, 1'b1);
    end_sim();
  end
endmodule
